// file: design/dcc_pkg.sv
package dcc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] DCC_OFS_PORT_A  = 8'h05;
  localparam logic [7:0] DCC_OFS_INTCTL  = 8'h0b;
  localparam logic [7:0] DCC_OFS_PFLAG1  = 8'h0c;
  localparam logic [7:0] DCC_OFS_CMPCTL  = 8'h1f;
  localparam logic [7:0] DCC_OFS_PADIR   = 8'h85;
  localparam logic [7:0] DCC_OFS_PEN1    = 8'h8c;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] DCC_RST_ZERO    = 8'h00;
  localparam logic [7:0] DCC_RST_PADIR   = 8'hff;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int DCC_BIT_RES2    = 7;
  localparam int DCC_BIT_RES1    = 6;
  localparam int DCC_BIT_INV2    = 5;
  localparam int DCC_BIT_INV1    = 4;
  localparam int DCC_BIT_SWITCH  = 3;
  localparam int DCC_BIT_CHGFLAG = 6;
  localparam int DCC_BIT_CHGEN   = 6;
  localparam int DCC_BIT_PERIEN  = 6;
  localparam int DCC_BIT_GLOBEN  = 7;
  localparam int DCC_BIT_PF1_RSV = 3;
  localparam int DCC_PIN_OUT1    = 3;
  localparam int DCC_PIN_OUT2    = 4;
  localparam int DCC_SYNC_W      = 7;
  // ----------------------------------------
  // comparator modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    DCC_M_RESET   = 3'b000,
    DCC_M_OUT_SW  = 3'b001,
    DCC_M_IREF    = 3'b010,
    DCC_M_COMREF  = 3'b011,
    DCC_M_INDEP   = 3'b100,
    DCC_M_SINGLE  = 3'b101,
    DCC_M_OUT_COM = 3'b110,
    DCC_M_OFF     = 3'b111
  } dcc_mode_type;
endpackage : dcc_pkg

// file: design/dcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_sync (
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic [dcc_pkg::DCC_SYNC_W-1:0] async_in,
  output var  logic [dcc_pkg::DCC_SYNC_W-1:0] sync_out
);
  import dcc_pkg::*;

  // ----------------------------------------
  // two-stage synchroniser
  // ----------------------------------------
  // stage one feeds stage two only
  logic [DCC_SYNC_W-1:0] meta_r;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : dcc_sync
`default_nettype wire

// file: design/dcc_top.sv
// Function
// - result high when positive input exceeds negative
// - mode 010 puts reference on positives
// - result bits 7:6 readable, writes ignored
// - modes 110/001 drive results onto pins
// - direction bits still gate pin drivers
// - analog pins read zero on port
// - any result change sets change flag
// - flag cleared by writing 0, 1 sets
// - request needs three enables all set
// - flag sets even with enables clear
// - access-cycle change still sets flag
// - control access refreshes change reference
// - mismatch keeps setting flag each cycle
// - comparators run in sleep, wake device
// - mode 111 powers off both comparators
// - wake leaves control register unchanged
// - reset clears control, comparators off
// - invert bits flip reported results
// - switch bit picks negative input pins in modes 001/010
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dcc_top (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       cmp1_raw,
  input  wire logic       cmp2_raw,
  input  wire logic [4:0] port_a_pin_in,
  input  wire logic       sleep_active,
  output var  logic       port_a_pin3_out,
  output var  logic       port_a_pin3_oe_n,
  output var  logic       port_a_pin4_out,
  output var  logic       port_a_pin4_oe_n,
  output var  logic [2:0] cmp_mode,
  output var  logic       cmp_power_on,
  output var  logic       vref_to_pos,
  output var  logic       neg_switch_hi,
  output var  logic       irq_request,
  output var  logic       wake_request
);
  import dcc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pins held analog in each mode (pins 3..0)
  function automatic logic [3:0] analog_mask(
    input logic [2:0] m
  );
    case (m)
      DCC_M_RESET:   analog_mask = 4'hf;
      DCC_M_OUT_SW:  analog_mask = 4'h7;
      DCC_M_IREF:    analog_mask = 4'hf;
      DCC_M_COMREF:  analog_mask = 4'h7;
      DCC_M_INDEP:   analog_mask = 4'hf;
      DCC_M_SINGLE:  analog_mask = 4'h6;
      DCC_M_OUT_COM: analog_mask = 4'h7;
      default:       analog_mask = 4'h0;
    endcase
  endfunction : analog_mask

  function automatic logic pins_driven(
    input logic [2:0] m
  );
    pins_driven = (m == DCC_M_OUT_COM) ||
                  (m == DCC_M_OUT_SW);
  endfunction : pins_driven

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cmpctl_r;
  logic [7:0] intctl_r;
  logic [7:0] pflag1_r;
  logic [7:0] pen1_r;
  logic [7:0] padir_r;
  logic [7:0] port_a_r;
  logic [1:0] ref_r;

  logic [DCC_SYNC_W-1:0] sync_q;
  logic [1:0] res;
  logic [4:0] pins_q;
  logic [2:0] mode;
  logic       powered;
  logic       mismatch;
  logic       cmp_access;
  logic       wr_cmpctl;
  logic       wr_pflag1;
  logic [3:0] amask;

  assign mode    = cmpctl_r[2:0];
  // mode 000 holds comparators in reset as well
  assign powered = (mode != DCC_M_OFF) &&
                   (mode != DCC_M_RESET);
  assign amask   = analog_mask(mode);
  assign pins_q  = sync_q[6:2];

  // ----------------------------------------
  // result path
  // ----------------------------------------
  // analog side already delivers high for vin+ above vin-
  dcc_sync u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({port_a_pin_in, cmp2_raw, cmp1_raw}),
    .sync_out (sync_q)
  );

  assign res[0] = powered &
                  (sync_q[0] ^ cmpctl_r[DCC_BIT_INV1]);
  assign res[1] = powered &
                  (sync_q[1] ^ cmpctl_r[DCC_BIT_INV2]);

  assign cmp_access = (reg_wr | reg_rd) &&
                      (reg_addr == DCC_OFS_CMPCTL);
  assign wr_cmpctl  = reg_wr && (reg_addr == DCC_OFS_CMPCTL);
  assign wr_pflag1  = reg_wr && (reg_addr == DCC_OFS_PFLAG1);
  assign mismatch   = (res != ref_r);

  // ----------------------------------------
  // change reference latch
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_r <= 2'h0;
    end else if (cmp_access) begin
      ref_r <= res;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // result bits are never stored; sleep has no path here
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmpctl_r <= DCC_RST_ZERO;
    end else if (wr_cmpctl) begin
      cmpctl_r <= {2'h0, reg_wdata[5:0]};
    end
  end

  // ----------------------------------------
  // change flag register
  // ----------------------------------------
  // a mismatch beats a software clear in the same cycle,
  // so the access-cycle race never drops an event
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pflag1_r <= DCC_RST_ZERO;
    end else begin
      if (wr_pflag1) begin
        pflag1_r <= reg_wdata;
        pflag1_r[DCC_BIT_PF1_RSV] <= 1'b0;
      end
      if (mismatch) begin
        pflag1_r[DCC_BIT_CHGFLAG] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // enable and port registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      intctl_r <= DCC_RST_ZERO;
      pen1_r   <= DCC_RST_ZERO;
      padir_r  <= DCC_RST_PADIR;
      port_a_r <= DCC_RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        DCC_OFS_INTCTL: intctl_r <= reg_wdata;
        DCC_OFS_PEN1:   pen1_r   <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
        DCC_OFS_PADIR:  padir_r  <= reg_wdata;
        DCC_OFS_PORT_A: port_a_r <= reg_wdata;
        default:        ;
      endcase
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= DCC_RST_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        DCC_OFS_CMPCTL: reg_rdata <= {res, cmpctl_r[5:0]};
        DCC_OFS_INTCTL: reg_rdata <= intctl_r;
        DCC_OFS_PFLAG1: reg_rdata <= pflag1_r;
        DCC_OFS_PEN1:   reg_rdata <= pen1_r;
        DCC_OFS_PADIR:  reg_rdata <= padir_r;
        DCC_OFS_PORT_A: reg_rdata <= {3'h0, pins_q[4],
                                      pins_q[3:0] & ~amask};
        default:        reg_rdata <= DCC_RST_ZERO;
      endcase
    end else begin
      reg_rdata <= DCC_RST_ZERO;
    end
  end

  // ----------------------------------------
  // analog mux controls
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmp_mode      <= DCC_M_RESET;
      cmp_power_on  <= 1'b0;
      vref_to_pos   <= 1'b0;
      neg_switch_hi <= 1'b0;
    end else begin
      cmp_mode      <= mode;
      cmp_power_on  <= powered;
      vref_to_pos   <= (mode == DCC_M_IREF);
      neg_switch_hi <= cmpctl_r[DCC_BIT_SWITCH] &&
                       ((mode == DCC_M_OUT_SW) ||
                        (mode == DCC_M_IREF));
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // pins follow the synchronised result: feeding the raw input
  // straight into logic would risk metastable pin drive
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      port_a_pin3_out  <= 1'b0;
      port_a_pin4_out  <= 1'b0;
      port_a_pin3_oe_n <= 1'b1;
      port_a_pin4_oe_n <= 1'b1;
    end else begin
      if (pins_driven(mode)) begin
        port_a_pin3_out <= res[0];
        port_a_pin4_out <= res[1];
      end else begin
        port_a_pin3_out <= port_a_r[DCC_PIN_OUT1];
        port_a_pin4_out <= port_a_r[DCC_PIN_OUT2];
      end
      port_a_pin3_oe_n <= padir_r[DCC_PIN_OUT1];
      port_a_pin4_oe_n <= padir_r[DCC_PIN_OUT2];
    end
  end

  // ----------------------------------------
  // interrupt and wake requests
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_request  <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      irq_request  <= pflag1_r[DCC_BIT_CHGFLAG] &
                      pen1_r[DCC_BIT_CHGEN] &
                      intctl_r[DCC_BIT_PERIEN] &
                      intctl_r[DCC_BIT_GLOBEN];
      wake_request <= sleep_active &
                      pflag1_r[DCC_BIT_CHGFLAG] &
                      pen1_r[DCC_BIT_CHGEN];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cmp_read;
    reg_rd && (reg_addr == DCC_OFS_CMPCTL);
  endsequence

  sequence s_flag_clear;
    wr_pflag1 && !reg_wdata[DCC_BIT_CHGFLAG] && !mismatch;
  endsequence

  property p_flag_on_change;
    @(posedge mclk) disable iff (reset)
      mismatch |=> pflag1_r[DCC_BIT_CHGFLAG];
  endproperty
  a_flag_on_change: assert property (p_flag_on_change)
    else $error("change flag missed a mismatch");

  property p_flag_clear;
    @(posedge mclk) disable iff (reset)
      s_flag_clear |=> !pflag1_r[DCC_BIT_CHGFLAG];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("writing zero did not clear flag");

  property p_flag_holds;
    @(posedge mclk) disable iff (reset)
      (pflag1_r[DCC_BIT_CHGFLAG] && !wr_pflag1)
        |=> pflag1_r[DCC_BIT_CHGFLAG];
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("change flag dropped without a clear");

  property p_irq_gate;
    @(posedge mclk) disable iff (reset)
      irq_request |-> $past(pflag1_r[DCC_BIT_CHGFLAG]) &&
        $past(pen1_r[DCC_BIT_CHGEN]) &&
        $past(intctl_r[DCC_BIT_PERIEN]) &&
        $past(intctl_r[DCC_BIT_GLOBEN]);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised without all enables");

  property p_ref_update;
    @(posedge mclk) disable iff (reset)
      cmp_access |=> (ref_r == $past(res));
  endproperty
  a_ref_update: assert property (p_ref_update)
    else $error("reference not refreshed on access");

  property p_result_read;
    @(posedge mclk) disable iff (reset)
      s_cmp_read |=> (reg_rdata[7:6] == $past(res));
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("result bits read wrong");

  property p_pin_result;
    @(posedge mclk) disable iff (reset)
      pins_driven(mode) |=> (port_a_pin3_out == $past(res[0])) &&
        (port_a_pin4_out == $past(res[1]));
  endproperty
  a_pin_result: assert property (p_pin_result)
    else $error("pin does not carry comparator result");

  property p_pin_enable;
    @(posedge mclk) disable iff (reset)
      ##1 (port_a_pin4_oe_n == $past(padir_r[DCC_PIN_OUT2]));
  endproperty
  a_pin_enable: assert property (p_pin_enable)
    else $error("direction bit not gating driver");

  property p_analog_zero;
    @(posedge mclk) disable iff (reset)
      (reg_rd && (reg_addr == DCC_OFS_PORT_A) &&
       (mode == DCC_M_RESET)) |=> (reg_rdata[3:0] == 4'h0);
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read not zero");

  property p_off_mode;
    @(posedge mclk) disable iff (reset)
      (mode == DCC_M_OFF) [*2] |-> !cmp_power_on && (res == 2'h0);
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("comparators powered in off mode");

  property p_vref_mode;
    @(posedge mclk) disable iff (reset)
      (mode == DCC_M_IREF) |=> vref_to_pos;
  endproperty
  a_vref_mode: assert property (p_vref_mode)
    else $error("reference not routed in mode 010");
endmodule : dcc_top
`default_nettype wire

// file: testbench/dcc_analog_src.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_analog_src (
  input  wire logic [7:0] lvl0,
  input  wire logic [7:0] lvl1,
  input  wire logic [7:0] lvl2,
  input  wire logic [7:0] lvl3,
  input  wire logic [7:0] lvl_ref,
  input  wire logic [4:0] ext_dig,
  input  wire logic       vref_to_pos,
  input  wire logic       neg_switch_hi,
  input  wire logic       pin3_out,
  input  wire logic       pin3_oe_n,
  input  wire logic       pin4_out,
  input  wire logic       pin4_oe_n,
  output var  logic       cmp1_raw,
  output var  logic       cmp2_raw,
  output var  logic [4:0] pin_lvl
);
  logic [7:0] pos1;
  logic [7:0] neg1;
  logic [7:0] pos2;
  logic [7:0] neg2;
  always_comb begin
    pos1 = vref_to_pos ? lvl_ref : lvl3;
    pos2 = vref_to_pos ? lvl_ref : lvl2;
    neg1 = neg_switch_hi ? lvl3 : lvl0;
    neg2 = neg_switch_hi ? lvl2 : lvl1;
    cmp1_raw = pos1 > neg1;
    cmp2_raw = pos2 > neg2;
    // a driven pin sees its own driver, a released one the outside level
    pin_lvl = ext_dig;
    if (!pin3_oe_n) begin
      pin_lvl[3] = pin3_out;
    end
    if (!pin4_oe_n) begin
      pin_lvl[4] = pin4_out;
    end
  end
endmodule : dcc_analog_src
`default_nettype wire

// file: testbench/dual_comparator_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module dual_comparator_control_test;
  import dcc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_active = 1'b0;
  logic [7:0] lv0 = 8'h0a, lv1 = 8'h0a, lv2 = 8'hc8, lv3 = 8'hc8;
  logic [4:0] ext_dig = 5'h1f;
  logic c1, c2, p3, p3n, p4, p4n, pwr, vref, nsw, irq, wake;
  logic [4:0] pins;
  logic [2:0] mode;
  int miscompares = 0;
  int comparisons = 0;
  // mode masks, one nibble per mode, mode 7 in the top nibble
  localparam logic [31:0] MASKS = 32'h076f_7f7f;
  dcc_top u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmp1_raw(c1), .cmp2_raw(c2),
    .port_a_pin_in(pins), .sleep_active(sleep_active),
    .port_a_pin3_out(p3), .port_a_pin3_oe_n(p3n),
    .port_a_pin4_out(p4), .port_a_pin4_oe_n(p4n), .cmp_mode(mode),
    .cmp_power_on(pwr), .vref_to_pos(vref), .neg_switch_hi(nsw),
    .irq_request(irq), .wake_request(wake));
  dcc_analog_src u_src (.lvl0(lv0), .lvl1(lv1), .lvl2(lv2), .lvl3(lv3),
    .lvl_ref(8'h80), .ext_dig(ext_dig), .vref_to_pos(vref),
    .neg_switch_hi(nsw), .pin3_out(p3), .pin3_oe_n(p3n), .pin4_out(p4),
    .pin4_oe_n(p4n), .cmp1_raw(c1), .cmp2_raw(c2), .pin_lvl(pins));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(DCC_OFS_CMPCTL, 8'h00);
    rd(DCC_OFS_PFLAG1, 8'h00);
    rd(DCC_OFS_PEN1, 8'h00);
    rd(DCC_OFS_PADIR, 8'hff);
    rd(8'h40, 8'h00);
    `CHK(pwr, 1'b0)
    tend("reset");
    // settle time after every mode change before trusting results
    wr(DCC_OFS_CMPCTL, 8'h04);
    cyc(6);
    rd(DCC_OFS_CMPCTL, 8'hc4);
    wr(DCC_OFS_CMPCTL, 8'hf4);
    cyc(6);
    rd(DCC_OFS_CMPCTL, 8'h34);
    wr(DCC_OFS_PFLAG1, 8'h00);
    rd(DCC_OFS_PFLAG1, 8'h00);
    tend("results");
    lv0 <= 8'hfa;
    cyc(6);
    rd(DCC_OFS_PFLAG1, 8'h40);
    `CHK(irq, 1'b0)
    wr(DCC_OFS_PFLAG1, 8'h00);
    rd(DCC_OFS_PFLAG1, 8'h40);
    rd(DCC_OFS_CMPCTL, 8'h74);
    wr(DCC_OFS_PFLAG1, 8'h00);
    rd(DCC_OFS_PFLAG1, 8'h00);
    tend("change");
    wr(DCC_OFS_PEN1, 8'h40);
    wr(DCC_OFS_INTCTL, 8'hc0);
    cyc(3);
    `CHK(irq, 1'b0)
    wr(DCC_OFS_PFLAG1, 8'h40);
    cyc(3);
    `CHK(irq, 1'b1)
    wr(DCC_OFS_INTCTL, 8'h40);
    cyc(3);
    `CHK(irq, 1'b0)
    @(posedge mclk);
    sleep_active <= 1'b1;
    cyc(3);
    `CHK(wake, 1'b1)
    @(posedge mclk);
    sleep_active <= 1'b0;
    cyc(3);
    `CHK(wake, 1'b0)
    rd(DCC_OFS_CMPCTL, 8'h74);
    wr(DCC_OFS_PFLAG1, 8'h00);
    tend("interrupt");
    wr(DCC_OFS_CMPCTL, 8'h0a);
    cyc(3);
    `CHK({vref, nsw, pwr}, 3'b111)
    wr(DCC_OFS_CMPCTL, 8'h0c);
    cyc(3);
    `CHK({vref, nsw}, 2'b00)
    tend("routing");
    wr(DCC_OFS_PADIR, 8'he7);
    wr(DCC_OFS_CMPCTL, 8'h06);
    cyc(6);
    `CHK({p4, p3, p4n, p3n}, 4'b1000)
    lv0 <= 8'h0a;
    cyc(4);
    `CHK(p3, 1'b1)
    wr(DCC_OFS_PADIR, 8'hff);
    cyc(3);
    `CHK({p4n, p3n}, 2'b11)
    tend("pins");
    for (int m = 0; m < 8; m++) begin
      wr(DCC_OFS_CMPCTL, 8'(m));
      cyc(4);
      `CHK(mode, 3'(m))
      `CHK(pwr, logic'(m != 0 && m != 7))
      `CHK(vref, logic'(m == 2))
      rd(DCC_OFS_PORT_A, {4'h1, ~MASKS[m*4+:4]});
    end
    tend("modes");
    wr(DCC_OFS_CMPCTL, 8'h15);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(DCC_OFS_CMPCTL, 8'h00);
    rd(DCC_OFS_PADIR, 8'hff);
    `CHK({pwr, mode}, 4'h0)
    tend("rereset");
    test_done;
  end
  initial begin
    #(25 * 5000);
    miscompares++;
    test_done;
  end
endmodule : dual_comparator_control_test
`default_nettype wire
